// >>> rtl/twrs_if.sv
`timescale 1ns/100ps
`default_nettype none
interface twrs_if;
  // master side of both open-drain lines
  logic scl_m_oe;
  logic sda_m_oe;
  // slave side of the data line
  logic sda_s_oe;
  // wired-and levels; a released line reads high through the pull-up
  logic scl;
  logic serial_data_line;
  assign scl = ~scl_m_oe;
  assign serial_data_line = ~(sda_m_oe | sda_s_oe);
  modport slave (input scl, input serial_data_line, output sda_s_oe);
  modport master (input scl, input serial_data_line, output scl_m_oe, output sda_m_oe);
endinterface
`default_nettype wire

// >>> rtl/twrs_master.sv
`timescale 1ns/100ps
`default_nettype none
// master: one command moves one byte-stream transaction
module twrs_master (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // two-wire link
  twrs_if.master bus,
  // command
  input wire logic cmd_go,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_data,
  input wire logic [3:0] cmd_len,
  // answer
  output logic done,
  output logic nack,
  output logic rd_stb,
  output logic [7:0] rd_data,
  output logic cmd_busy
);
  typedef enum logic [5:0] {
    M_IDLE = 6'b000001,
    M_START = 6'b000010,
    M_BYTE = 6'b000100,
    M_ACK = 6'b001000,
    M_STOP = 6'b010000,
    M_DONE = 6'b100000
  } twrs_mst_e;

  twrs_mst_e st_r;
  logic [7:0] div_r;
  logic tick;
  logic [1:0] ph_r;
  logic scl_oe_r, sda_oe_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [3:0] left_r;
  logic [1:0] stage_r;
  logic rd_r, done_r, nack_r, rd_stb_r;
  logic [7:0] rd_data_r;
  logic sda_meta_r, sda_sync_r;
  logic cmd_busy_r;

  // read-back of the data line crosses in through two flops
  always_ff @(posedge clk) begin
    if (reset) begin
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      sda_meta_r <= bus.serial_data_line;
      sda_sync_r <= sda_meta_r;
    end
  end

  // quarter-bit enable from the divider
  always_ff @(posedge clk) begin
    if (reset || st_r == M_IDLE) begin
      div_r <= 8'h00;
    end else if (tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign tick = (st_r != M_IDLE) && (div_r == (twrs_pkg::HALF_PERIOD >> 1) - 8'h01);

  // ------------------------------------------------------------
  // bit engine: ph 0 clock low set data, 1 raise, 2 sample, 3 lower
  // stage 0 address, 1 pointer, 2 data/rd address, 3 read data
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= M_IDLE;
      ph_r <= 2'h0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      left_r <= 4'h0;
      stage_r <= 2'h0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      rd_stb_r <= 1'b0;
      rd_data_r <= 8'h00;
      cmd_busy_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      rd_stb_r <= 1'b0;
      case (st_r)
        M_IDLE: begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
          if (cmd_go) begin
            rd_r <= cmd_read;
            left_r <= cmd_len;
            sh_r <= twrs_pkg::ADDR_WR;
            stage_r <= 2'h0;
            nack_r <= 1'b0;
            cmd_busy_r <= 1'b1;
            ph_r <= 2'h0;
            st_r <= M_START;
          end
        end
        M_START: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: begin
              scl_oe_r <= 1'b0;
              sda_oe_r <= 1'b0;
            end
            2'h1: sda_oe_r <= 1'b1;
            2'h2: scl_oe_r <= 1'b1;
            default: begin
              st_r <= M_BYTE;
              bit_r <= 4'h0;
            end
          endcase
        end
        M_BYTE: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_oe_r <= (stage_r == 2'h3) ? 1'b0 : ~sh_r[7];
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sh_r <= {sh_r[6:0], sda_sync_r};
            default: begin
              scl_oe_r <= 1'b1;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h7) begin
                st_r <= M_ACK;
              end
            end
          endcase
        end
        M_ACK: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_oe_r <= (stage_r == 2'h3) && (left_r != 4'h1);
            2'h1: scl_oe_r <= 1'b0;
            2'h2: if (stage_r != 2'h3 && sda_sync_r) nack_r <= 1'b1;
            default: begin
              scl_oe_r <= 1'b1;
              bit_r <= 4'h0;
              if (stage_r == 2'h3) begin
                rd_stb_r <= 1'b1;
                rd_data_r <= sh_r;
                left_r <= left_r - 4'h1;
                if (left_r == 4'h1) begin
                  st_r <= M_STOP;
                end else begin
                  st_r <= M_BYTE;
                end
              end else if (nack_r) begin
                st_r <= M_STOP;
              end else if (stage_r == 2'h0) begin
                sh_r <= cmd_ptr;
                stage_r <= 2'h1;
                st_r <= M_BYTE;
              end else if (stage_r == 2'h1 && rd_r) begin
                sh_r <= twrs_pkg::ADDR_RD;
                stage_r <= 2'h2;
                st_r <= M_START;
              end else if (stage_r == 2'h2 && rd_r) begin
                stage_r <= 2'h3;
                st_r <= M_BYTE;
              end else if (left_r == 4'h0) begin
                st_r <= M_STOP;
              end else begin
                sh_r <= cmd_data;
                left_r <= left_r - 4'h1;
                stage_r <= 2'h2;
                st_r <= M_BYTE;
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            default: st_r <= M_DONE;
          endcase
        end
        M_DONE: begin
          done_r <= 1'b1;
          cmd_busy_r <= 1'b0;
          st_r <= M_IDLE;
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end

  assign bus.scl_m_oe = scl_oe_r;
  assign bus.sda_m_oe = sda_oe_r;
  assign done = done_r;
  assign nack = nack_r;
  assign rd_stb = rd_stb_r;
  assign rd_data = rd_data_r;
  assign cmd_busy = cmd_busy_r;
endmodule
`default_nettype wire

// >>> rtl/twrs_pkg.sv
package twrs_pkg;
  // address byte values: write DCh, read DDh
  localparam logic [6:0] DEV_ADDR = 7'h6E;
  localparam logic [7:0] ADDR_WR = 8'hDC;
  localparam logic [7:0] ADDR_RD = 8'hDD;
  // highest valid register index; writes beyond it are dropped
  localparam logic [7:0] REG_LAST = 8'hEF;
  localparam int REG_COUNT = 240;
  // master serial clock divider: half period in clk cycles (40 MHz / 200 = 200 kHz)
  localparam logic [7:0] HALF_PERIOD = 8'h64;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// >>> rtl/twrs_slave.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - high-to-low data while clock high starts
// - low-to-high data while clock high stops
// - first byte: 7-bit address, direction LSB
// - answer only to DCh write, DDh read
// - data changes only while clock low
// - eight data bits then acknowledge pulse
// - transmitter releases, receiver pulls low
// - no-acknowledge ends read, slave releases
// - slave acknowledges matching address
// - write: pointer byte follows, acknowledged
// - each data byte writes one register
// - pointer increments after each written byte
// - master ends write with stop/start
// - pointer increments after each read byte
// - out-of-range writes ignored, reads undefined
// - lines only pulled low or released
module twrs_slave (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // two-wire link
  twrs_if.slave bus,
  // register file observation
  output logic [7:0] reg_ptr,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic busy
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_RX = 5'b00100,
    ST_TX = 5'b01000,
    ST_ACK = 5'b10000
  } twrs_st_e;

  logic scl_lv, scl_rise, scl_fall;
  logic sda_lv, sda_rise, sda_fall;
  twrs_sync u_scl (.clk(clk), .reset(reset), .pin(bus.scl), .level(scl_lv),
    .rise(scl_rise), .fall(scl_fall));
  twrs_sync u_sda (.clk(clk), .reset(reset), .pin(bus.serial_data_line), .level(sda_lv),
    .rise(sda_rise), .fall(sda_fall));

  twrs_st_e st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic is_read_r;
  logic ptr_phase_r;
  logic ack_from_m_r;
  logic sda_oe_r;
  logic [7:0] ptr_r;
  logic [7:0] regs_r [0:twrs_pkg::REG_COUNT-1];
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic busy_r;

  function automatic logic in_range(input logic [7:0] a);
    in_range = (a <= twrs_pkg::REG_LAST);
  endfunction

  logic start_c, stop_c;
  assign start_c = sda_fall & scl_lv;
  assign stop_c = sda_rise & scl_lv;

  // ------------------------------------------------------------
  // protocol state
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      is_read_r <= 1'b0;
      ptr_phase_r <= 1'b0;
      ack_from_m_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ptr_r <= 8'h00;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_c) begin
        // repeated start keeps the pointer for the read that follows
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_lv};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              if (st_r == ST_ADDR) begin
                if (sh_r[7:1] == twrs_pkg::DEV_ADDR) begin
                  is_read_r <= sh_r[0];
                  ptr_phase_r <= ~sh_r[0];
                  ack_from_m_r <= 1'b0;
                  sda_oe_r <= 1'b1;
                  st_r <= ST_ACK;
                end else begin
                  st_r <= ST_IDLE;
                end
              end else begin
                if (ptr_phase_r) begin
                  ptr_r <= sh_r;
                  ptr_phase_r <= 1'b0;
                end else begin
                  if (in_range(ptr_r)) begin
                    wr_stb_r <= 1'b1;
                    wr_addr_r <= ptr_r;
                    wr_data_r <= sh_r;
                  end
                  ptr_r <= ptr_r + 8'h01;
                end
                ack_from_m_r <= 1'b0;
                sda_oe_r <= 1'b1;
                st_r <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // slave ack ends at falling edge; master ack sampled at rising edge
            if (ack_from_m_r && scl_rise) begin
              if (sda_lv) begin
                st_r <= ST_IDLE;
              end
            end else if (scl_fall) begin
              if (ack_from_m_r || is_read_r) begin
                st_r <= ST_TX;
                sh_r <= in_range(ptr_r) ? regs_r[ptr_r] : 8'hFF;
                sda_oe_r <= in_range(ptr_r) ? ~regs_r[ptr_r][7] : 1'b0;
                bit_r <= 4'h1;
              end else begin
                st_r <= ST_RX;
                sda_oe_r <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                ack_from_m_r <= 1'b1;
                ptr_r <= ptr_r + 8'h01;
                st_r <= ST_ACK;
              end else begin
                sda_oe_r <= ~sh_r[3'h7 - 3'(bit_r)];
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < twrs_pkg::REG_COUNT; i++) begin
        regs_r[i] <= twrs_pkg::REG_RESET;
      end
    end else if (wr_stb_r) begin
      regs_r[wr_addr_r] <= wr_data_r;
    end
  end

  // busy trails the state by one cycle so that the pin comes from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (st_r != ST_IDLE);
    end
  end

  assign bus.sda_s_oe = sda_oe_r;
  assign reg_ptr = ptr_r;
  assign wr_stb = wr_stb_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign busy = busy_r;
endmodule
`default_nettype wire

// >>> rtl/twrs_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser with edge detection on the synchronised level
module twrs_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pin side
  input wire logic pin,
  // synchronised side
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule
`default_nettype wire

// >>> verification/tb_two_wire_register_access_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tb_two_wire_register_access_slave;
  logic clk, reset, cmd_go, cmd_read, done, nack, rd_stb, m_busy, wr_stb, busy, got;
  logic [7:0] cmd_ptr, cmd_data, rd_data, reg_ptr, wr_addr, wr_data, reg_ptr_b;
  logic [3:0] cmd_len;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  int mismatches, num_checks;
  twrs_if bus_a();
  twrs_if bus_b();
  twrs_master twrs_master_inst (.clk(clk), .reset(reset), .bus(bus_a.master),
    .cmd_go(cmd_go), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .cmd_len(cmd_len), .done(done), .nack(nack), .rd_stb(rd_stb), .rd_data(rd_data),
    .cmd_busy(m_busy));
  twrs_slave twrs_slave_inst (.clk(clk), .reset(reset), .bus(bus_a.slave), .reg_ptr(reg_ptr),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
  // second slave faces the bench's bit driver, which can send foreign addresses
  twrs_slave twrs_slave_b_inst (.clk(clk), .reset(reset), .bus(bus_b.slave),
    .reg_ptr(reg_ptr_b), .wr_stb(), .wr_addr(), .wr_data(), .busy());
  twrs_chk twrs_chk_inst (.clk(clk), .reset(reset), .scl_m_oe(bus_a.scl_m_oe),
    .sda_m_oe(bus_a.sda_m_oe), .sda_s_oe(bus_a.sda_s_oe), .scl(bus_a.scl),
    .serial_data_line(bus_a.serial_data_line));
  // --------
  // clock, capture and tasks
  // --------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rd_stb === 1'b1) rq.push_back(rd_data);
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task complete_run;
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t byte %h exp %h", $time, g, e);
    end
  endtask
  task run(input logic rd, input logic [7:0] p, input logic [7:0] d, input logic [3:0] n);
    int i;
    wq.delete();
    rq.delete();
    cmd_read <= rd;
    cmd_ptr <= p;
    cmd_data <= d;
    cmd_len <= n;
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd_go <= 1'b0;
    @(posedge clk);
    chk1(m_busy, 1'b1);
    i = 0;
    while (done !== 1'b1 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    chk1(done, 1'b1);
    chk1(nack, 1'b0);
    chk1(m_busy, 1'b0);
    wt(4);
  endtask
  task exp_wr(input logic [7:0] b, input logic [7:0] d, input logic [7:0] n);
    chk8(8'(wq.size()), n);
    for (int k = 0; k < n; k++) begin
      chk8(wq[k][15:8], b + 8'(k));
      chk8(wq[k][7:0], d);
    end
  endtask
  // bench bit driver: 200 ns link period, data moved only while clock low
  task bb_bit(input logic b, output logic g);
    wt(2);
    bus_b.sda_m_oe <= ~b;
    wt(2);
    bus_b.scl_m_oe <= 1'b0;
    wt(3);
    g = bus_b.serial_data_line;
    wt(1);
    bus_b.scl_m_oe <= 1'b1;
  endtask
  task bb_byte(input logic [7:0] v, output logic ack);
    for (int k = 7; k >= 0; k--) bb_bit(v[k], ack);
    bb_bit(1'b1, ack);
  endtask
  task bb_start;
    wt(2);
    bus_b.sda_m_oe <= 1'b1;
    wt(4);
    bus_b.scl_m_oe <= 1'b1;
  endtask
  task bb_stop;
    wt(2);
    bus_b.sda_m_oe <= 1'b1;
    wt(2);
    bus_b.scl_m_oe <= 1'b0;
    wt(4);
    bus_b.sda_m_oe <= 1'b0;
    wt(4);
  endtask
  // --------
  // tests
  // --------
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {cmd_go, cmd_read, cmd_ptr, cmd_data, cmd_len} = '0;
    bus_b.scl_m_oe = 1'b0;
    bus_b.sda_m_oe = 1'b0;
    mismatches = 0;
    num_checks = 0;
    wt(8);
    reset <= 1'b0;
    wt(2);
    run(1'b0, 8'h10, 8'hA5, 4'h3);
    exp_wr(8'h10, 8'hA5, 8'h03);
    chk8(reg_ptr, 8'h13);
    chk1(busy, 1'b0);
    run(1'b0, 8'hEE, 8'h3C, 4'h3);
    exp_wr(8'hEE, 8'h3C, 8'h02);
    run(1'b1, 8'h10, 8'h00, 4'h4);
    chk8(8'(rq.size()), 8'h04);
    for (int k = 0; k < 3; k++) chk8(rq[k], 8'hA5);
    chk8(rq[3], twrs_pkg::REG_RESET);
    run(1'b1, 8'hEF, 8'h00, 4'h2);
    chk8(rq[0], 8'h3C);
    chk8(rq[1], 8'hFF);
    run(1'b0, 8'h20, 8'h77, 4'h0);
    exp_wr(8'h20, 8'h77, 8'h00);
    chk8(reg_ptr, 8'h20);
    chk1(bus_a.scl, 1'b1);
    chk1(bus_a.serial_data_line, 1'b1);
    bb_start();
    bb_byte(8'hA4, got);
    chk1(got, 1'b1);
    bb_byte(twrs_pkg::ADDR_WR, got);
    chk1(got, 1'b1);
    bb_stop();
    bb_start();
    bb_byte(twrs_pkg::ADDR_WR, got);
    chk1(got, 1'b0);
    bb_byte(8'h33, got);
    chk1(got, 1'b0);
    bb_stop();
    chk8(reg_ptr_b, 8'h33);
    complete_run();
  end
endmodule
`default_nettype wire

// >>> verification/twrs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module twrs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link lines
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic serial_data_line
);
  logic scl_r, sda_r, rd_r, nack_r;
  logic [3:0] cnt_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  wire logic start_w = scl && scl_r && sda_r && !serial_data_line;
  // --------
  // bit tracker, raw lines; restarted at every start so a repeated start realigns it
  // --------
  always_ff @(posedge clk) begin
    scl_r <= scl;
    sda_r <= serial_data_line;
  end
  always_ff @(posedge clk) begin
    if (reset || start_w) begin
      cnt_r <= 4'h0;
      byte_r <= 2'h0;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (scl && !scl_r) begin
      sh_r <= {sh_r[6:0], serial_data_line};
      if (byte_r == 2'h0 && cnt_r == 4'h7) begin
        rd_r <= serial_data_line;
      end
      if (cnt_r == 4'h8) begin
        cnt_r <= 4'h0;
        if (byte_r != 2'h3) begin
          byte_r <= byte_r + 2'h1;
        end
        if (rd_r && byte_r != 2'h0 && serial_data_line) begin
          nack_r <= 1'b1;
        end
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
  // --------
  // link properties
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ack9;
    $rose(scl) && cnt_r == 4'h8;
  endsequence
  sequence s_start;
    scl && $past(scl) && $fell(serial_data_line);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(serial_data_line);
  endsequence
  AST_ADDR_ACK: assert property (
    s_ack9 ##0 (byte_r == 2'h0) |-> serial_data_line ==
      !(sh_r == twrs_pkg::ADDR_WR || sh_r == twrs_pkg::ADDR_RD))
    else $error("address byte answered wrongly");
  AST_WR_ACK: assert property (
    s_ack9 ##0 (byte_r != 2'h0 && !rd_r) |-> !serial_data_line)
    else $error("written byte not acknowledged");
  AST_RD_RELEASE: assert property (
    s_ack9 ##0 (byte_r != 2'h0 && rd_r) |-> !sda_s_oe)
    else $error("slave holds line in read ack slot");
  AST_WR_QUIET: assert property (
    $rose(scl) && cnt_r < 4'h8 && !(rd_r && byte_r != 2'h0) |-> !sda_s_oe)
    else $error("slave drives while master transmits");
  AST_NACK_QUIET: assert property (nack_r |-> !sda_s_oe)
    else $error("slave drives after no-ack");
  AST_SLAVE_STABLE: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved while clock high");
  AST_START_FREE: assert property (s_start |-> !sda_s_oe)
    else $error("slave pulls line at start");
  AST_STOP_FREE: assert property (s_stop |-> !sda_s_oe)
    else $error("slave pulls line at stop");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_FRAME_QUIET: assert property (
    !scl_m_oe && !$past(scl_m_oe) && $changed(sda_m_oe) |-> !sda_s_oe)
    else $error("slave pulls line while master frames a transfer");
endmodule
`default_nettype wire
